// >>> design/vtu_cfg.svh
// constants for the vertical timing register block
`ifndef VTU_CFG_SVH
`define VTU_CFG_SVH
`define VTU_IDX_OVERFLOW 8'h07
`define VTU_IDX_START_LO 8'h0d
`define VTU_IDX_CUR_HI 8'h0e
`define VTU_IDX_CUR_LO 8'h0f
`define VTU_IDX_VRS_LO 8'h10
`define VTU_IDX_VRE 8'h11
`define VTU_IDX_VDE_LO 8'h12
`define VTU_IDX_PITCH 8'h13
`define VTU_IDX_ULINE 8'h14
`define VTU_IDX_VBS_LO 8'h15
`define VTU_IDX_VBE 8'h16
`define VTU_IDX_MODE 8'h17
`define VTU_RST_REG 8'h00
`define VTU_RST_INDEX 8'h00
`define VTU_VRE_WPROT 7
`define VTU_VRE_REF5 6
`define VTU_VRE_IRQ_DIS 5
`define VTU_VRE_IRQ_CLR_N 4
`define VTU_UL_DWORD 6
`define VTU_UL_COUNT4 5
`define VTU_MODE_RETRACE_EN 7
`define VTU_MODE_BYTE 6
`define VTU_MODE_WRAP 5
`define VTU_MODE_COUNT2 3
`define VTU_MODE_LINE_DIV2 2
`define VTU_LOCK_VREGS 0
`define VTU_LOCK_MODE 5
`define VTU_LOCK_EXT_LO 3
`define VTU_LOCK_EXT_HI 4
`define VTU_OVF_LC8 4
`define VTU_OVF_VDE8 1
`define VTU_OVF_VDE9 6
`define VTU_OVF_VRS8 2
`define VTU_OVF_VRS9 7
`define VTU_OVF_VBS8 3
`define VTU_MSL_VBS9 5
`define VTU_REFRESH_NORMAL 3'd3
`define VTU_REFRESH_MORE 3'd5
`define VTU_PITCH_K_BYTE 2
`define VTU_PITCH_K_WORD 4
`define VTU_PITCH_K_DWORD 8
`endif

// >>> design/vtu_pkg.sv
// types shared by the vertical timing register block
`default_nettype none
package vtu_pkg;
	typedef enum logic [1:0] {
		VTU_NATIVE,
		VTU_LEGACY_TEXT,
		VTU_ENHANCED
	} vtu_mode_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic sel_data;
		logic [7:0] wdata;
	} vtu_host_req_s;

	typedef struct packed {
		logic strobe;
		logic [2:0] index;
		logic [7:0] data;
		logic [7:0] mask;
	} vtu_low_wr_s;
endpackage
`default_nettype wire

// >>> design/vtu_addr_gen.sv
// display memory address counter with row pitch and access-width mapping
`default_nettype none
`include "vtu_cfg.svh"
module vtu_addr_gen #(
	parameter int AW = 18
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// timing steps
	input wire logic char_en,
	input wire logic line_step,
	input wire logic row_adv,
	input wire logic frame_start,
	input wire logic disp_on,
	// configuration
	input wire logic [AW-1:0] start_addr,
	input wire logic [7:0] pitch,
	input wire logic dword_mode,
	input wire logic byte_mode,
	input wire logic count4,
	input wire logic count2,
	input wire logic wrap_sel,
	// address out
	output logic [AW-1:0] mem_addr_q
);
	import vtu_pkg::*;

	logic [AW-1:0] row_start_q, row_start_d, ma_q, ma_d, pitch_step, mapped;
	logic [1:0] div_q;
	logic ma_tick;

	// K is 2 for byte, 4 for word, 8 for doubleword layout
	assign pitch_step = dword_mode ? AW'(pitch) * AW'(`VTU_PITCH_K_DWORD) :
		byte_mode ? AW'(pitch) * AW'(`VTU_PITCH_K_BYTE) : AW'(pitch) * AW'(`VTU_PITCH_K_WORD);
	// count by 4 takes precedence over count by 2
	assign ma_tick = char_en & (count4 ? (div_q == 2'd3) : count2 ? div_q[0] : 1'b1);
	assign row_start_d = frame_start ? start_addr : row_adv ? row_start_q + pitch_step : row_start_q;
	assign ma_d = (frame_start | line_step) ? row_start_d : (ma_tick & disp_on) ? ma_q + AW'(1) : ma_q;
	// doubleword drops two high bits and fills from bits 13 and 12, word drops one and fills from a high bit
	assign mapped = dword_mode ? {ma_q[AW-3:0], ma_q[13], ma_q[12]} :
		byte_mode ? ma_q : {ma_q[AW-2:0], wrap_sel ? ma_q[15] : ma_q[13]};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			row_start_q <= '0;
			ma_q <= '0;
			div_q <= 2'd0;
			mem_addr_q <= '0;
		end else begin
			row_start_q <= row_start_d;
			ma_q <= ma_d;
			div_q <= line_step ? 2'd0 : char_en ? div_q + 2'd1 : div_q;
			mem_addr_q <= mapped;
		end
	end
endmodule // vtu_addr_gen
`default_nettype wire

// >>> design/vtu_vert_regs.sv
// vertical timing, cursor and address registers behind the index/data port pair
// Behaviour
// - index 0x0d holds start address low byte
// - cursor high byte; address extended to 18 bits, or 14 bits in legacy text
// - index 0x0f holds cursor address low byte
// - retrace start is ten bits with overflow
// - legacy text reads light pen at 0x10/0x11, enhanced mode at 0x10 only
// - extension lock bit 0 blocks retrace and blank writes
// - write protect blocks 0x00-0x07 except line compare
// - three or five refresh cycles per line
// - interrupt enabled when bit 5 is 0
// - writing bit 4 low clears pending interrupt
// - interrupt raised at bottom border start
// - sync ends on low four bits match
// - display ends at ten-bit count, lines minus one
// - next row start adds K times offset
// - bit 6 of 0x14 selects doubleword addressing
// - count by 4 divides address clock
// - underline on row scan matching field
// - blank starts at ten-bit value plus one
// - blank ends on low eight bits match
// - extension lock bit 5 blocks mode writes
// - mode bit 7 gates retrace outputs
`default_nettype none
`include "vtu_cfg.svh"
module vtu_vert_regs #(
	parameter int AW = 18
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// host index/data port
	input wire vtu_pkg::vtu_host_req_s host_req,
	output logic [7:0] host_rdata_q,
	output logic [7:0] index_q,
	// neighbouring registers and extension lock
	input wire logic [7:0] ext_lock_reg,
	input wire logic [7:0] overflow_reg,
	input wire logic [7:0] max_scan_reg,
	input wire logic [7:0] start_addr_high,
	input wire logic [9:0] vert_total,
	input wire vtu_pkg::vtu_mode_e compat_mode,
	input wire logic [15:0] light_pen,
	// write path to indices 0x00-0x07
	output vtu_pkg::vtu_low_wr_s low_wr_q,
	// timing pulses
	input wire logic char_en,
	input wire logic line_en,
	input wire logic hretrace_in,
	// timing outputs
	output logic hsync_q,
	output logic vsync_q,
	output logic vblank_q,
	output logic vdisp_q,
	output logic vint_q,
	output logic refresh_req_q,
	output logic underline_q,
	output logic [AW-1:0] cursor_addr_q,
	output logic [AW-1:0] start_addr_q,
	output logic [AW-1:0] mem_addr_q
);
	import vtu_pkg::*;

	logic [7:0] start_lo_q, cur_hi_q, cur_lo_q, vrs_lo_q, vre_q, vde_lo_q;
	logic [7:0] pitch_q, ul_q, vbs_lo_q, vbe_q, mode_q;
	logic [9:0] vcnt_q, vrs, vde, vbs;
	logic [4:0] row_q;
	logic [2:0] ref_left_q;
	logic line_div_q, vs_flag_q, vb_flag_q, irq_pend_q;

	// host decode
	wire wr_index = host_req.wr & ~host_req.sel_data;
	wire wr_data = host_req.wr & host_req.sel_data;
	wire vlock = ext_lock_reg[`VTU_LOCK_VREGS];
	wire mlock = ext_lock_reg[`VTU_LOCK_MODE];
	wire wprot = vre_q[`VTU_VRE_WPROT];
	wire we_start_lo = wr_data & (index_q == `VTU_IDX_START_LO);
	wire we_cur_hi = wr_data & (index_q == `VTU_IDX_CUR_HI);
	wire we_cur_lo = wr_data & (index_q == `VTU_IDX_CUR_LO);
	wire we_vrs = wr_data & (index_q == `VTU_IDX_VRS_LO) & ~vlock;
	wire we_vre = wr_data & (index_q == `VTU_IDX_VRE) & ~vlock;
	wire we_vde = wr_data & (index_q == `VTU_IDX_VDE_LO);
	wire we_pitch = wr_data & (index_q == `VTU_IDX_PITCH);
	wire we_ul = wr_data & (index_q == `VTU_IDX_ULINE);
	wire we_vbs = wr_data & (index_q == `VTU_IDX_VBS_LO) & ~vlock;
	wire we_vbe = wr_data & (index_q == `VTU_IDX_VBE) & ~vlock;
	wire we_mode = wr_data & (index_q == `VTU_IDX_MODE) & ~mlock;
	wire low_hit = wr_data & (index_q[7:3] == 5'd0);
	wire is_ovf = index_q == `VTU_IDX_OVERFLOW;
	// under write protect only the line compare bit of the overflow register passes
	wire [7:0] low_mask = ~wprot ? 8'hff : is_ovf ? (8'h01 << `VTU_OVF_LC8) : 8'h00;
	wire legacy = compat_mode == VTU_LEGACY_TEXT;

	// read mux
	logic [7:0] rd_mux;
	always_comb begin
		unique case (index_q)
			`VTU_IDX_START_LO: rd_mux = start_lo_q;
			`VTU_IDX_CUR_HI: rd_mux = cur_hi_q;
			`VTU_IDX_CUR_LO: rd_mux = cur_lo_q;
			`VTU_IDX_VRS_LO: rd_mux = legacy ? {2'b00, light_pen[13:8]} :
				(compat_mode == VTU_ENHANCED) ? light_pen[15:8] : vrs_lo_q;
			`VTU_IDX_VRE: rd_mux = legacy ? light_pen[7:0] : vre_q;
			`VTU_IDX_VDE_LO: rd_mux = vde_lo_q;
			`VTU_IDX_PITCH: rd_mux = pitch_q;
			`VTU_IDX_ULINE: rd_mux = {1'b0, ul_q[6:0]};
			`VTU_IDX_VBS_LO: rd_mux = vbs_lo_q;
			`VTU_IDX_VBE: rd_mux = vbe_q;
			`VTU_IDX_MODE: rd_mux = {mode_q[7:5], 1'b0, mode_q[3:0]};
			default: rd_mux = 8'h00;
		endcase
	end

	// ten-bit compare values assembled from the neighbouring registers
	assign vrs = {overflow_reg[`VTU_OVF_VRS9], overflow_reg[`VTU_OVF_VRS8], vrs_lo_q};
	assign vde = {overflow_reg[`VTU_OVF_VDE9], overflow_reg[`VTU_OVF_VDE8], vde_lo_q};
	assign vbs = {max_scan_reg[`VTU_MSL_VBS9], overflow_reg[`VTU_OVF_VBS8], vbs_lo_q};

	// vertical counter runs at line rate, optionally halved
	wire line_step = line_en & (~mode_q[`VTU_MODE_LINE_DIV2] | line_div_q);
	wire vwrap = vcnt_q == vert_total;
	wire frame_start = line_step & vwrap;
	wire row_end = row_q == max_scan_reg[4:0];
	wire row_adv = line_step & row_end & ~vwrap;
	wire [9:0] vcnt_d = frame_start ? 10'd0 : line_step ? vcnt_q + 10'd1 : vcnt_q;

	// sync and blank flags, start wins over end on the same line
	wire vs_d = (vcnt_q == vrs) ? 1'b1 : (vcnt_q[3:0] == vre_q[3:0]) ? 1'b0 : vs_flag_q;
	wire vb_d = (vcnt_q == vbs + 10'd1) ? 1'b1 : (vcnt_q[7:0] == vbe_q) ? 1'b0 : vb_flag_q;
	wire vdisp_d = vcnt_q <= vde;
	wire retrace_en = mode_q[`VTU_MODE_RETRACE_EN];
	wire border_evt = vdisp_q & ~vdisp_d;
	wire irq_set = border_evt & vre_q[`VTU_VRE_IRQ_CLR_N];
	wire irq_clr = we_vre & ~host_req.wdata[`VTU_VRE_IRQ_CLR_N];
	wire [2:0] ref_load = vre_q[`VTU_VRE_REF5] ? `VTU_REFRESH_MORE : `VTU_REFRESH_NORMAL;
	wire ref_fire = char_en & (ref_left_q != 3'd0) & ~line_en;

	// cursor and start address, extended in every mode except legacy text
	wire [AW-1:0] cur_d = legacy ? AW'({cur_hi_q[5:0], cur_lo_q}) :
		{ext_lock_reg[`VTU_LOCK_EXT_HI:`VTU_LOCK_EXT_LO], cur_hi_q, cur_lo_q};
	wire [AW-1:0] start_d = legacy ? AW'({start_addr_high, start_lo_q}) :
		{ext_lock_reg[`VTU_LOCK_EXT_HI:`VTU_LOCK_EXT_LO], start_addr_high, start_lo_q};

	// register file
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			index_q <= `VTU_RST_INDEX;
			start_lo_q <= `VTU_RST_REG;
			cur_hi_q <= `VTU_RST_REG;
			cur_lo_q <= `VTU_RST_REG;
			vrs_lo_q <= `VTU_RST_REG;
			vre_q <= `VTU_RST_REG;
			vde_lo_q <= `VTU_RST_REG;
			pitch_q <= `VTU_RST_REG;
			ul_q <= `VTU_RST_REG;
			vbs_lo_q <= `VTU_RST_REG;
			vbe_q <= `VTU_RST_REG;
			mode_q <= `VTU_RST_REG;
		end else begin
			if (wr_index) index_q <= host_req.wdata;
			if (we_start_lo) start_lo_q <= host_req.wdata;
			if (we_cur_hi) cur_hi_q <= host_req.wdata;
			if (we_cur_lo) cur_lo_q <= host_req.wdata;
			if (we_vrs) vrs_lo_q <= host_req.wdata;
			if (we_vre) vre_q <= host_req.wdata;
			if (we_vde) vde_lo_q <= host_req.wdata;
			if (we_pitch) pitch_q <= host_req.wdata;
			if (we_ul) ul_q <= host_req.wdata;
			if (we_vbs) vbs_lo_q <= host_req.wdata;
			if (we_vbe) vbe_q <= host_req.wdata;
			if (we_mode) mode_q <= host_req.wdata;
		end
	end

	// host answers and write path to the low timing registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_rdata_q <= 8'h00;
			low_wr_q <= '0;
		end else begin
			if (host_req.rd) host_rdata_q <= host_req.sel_data ? rd_mux : index_q;
			low_wr_q.strobe <= low_hit & (low_mask != 8'h00);
			low_wr_q.index <= index_q[2:0];
			low_wr_q.data <= host_req.wdata;
			low_wr_q.mask <= low_mask;
		end
	end

	// vertical counter, row scan and flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vcnt_q <= 10'd0;
			row_q <= 5'd0;
			line_div_q <= 1'b0;
			vs_flag_q <= 1'b0;
			vb_flag_q <= 1'b0;
			vdisp_q <= 1'b0;
		end else begin
			if (line_en) line_div_q <= ~line_div_q;
			vcnt_q <= vcnt_d;
			if (line_step) row_q <= (vwrap | row_end) ? 5'd0 : row_q + 5'd1;
			vs_flag_q <= vs_d;
			vb_flag_q <= vb_d;
			vdisp_q <= vdisp_d;
		end
	end

	// outputs, interrupt and refresh
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vsync_q <= 1'b0;
			hsync_q <= 1'b0;
			vblank_q <= 1'b0;
			irq_pend_q <= 1'b0;
			vint_q <= 1'b0;
			ref_left_q <= 3'd0;
			refresh_req_q <= 1'b0;
			underline_q <= 1'b0;
			cursor_addr_q <= '0;
			start_addr_q <= '0;
		end else begin
			vsync_q <= vs_d & retrace_en;
			hsync_q <= hretrace_in & retrace_en;
			vblank_q <= vb_d;
			// a border event in the clearing cycle still sets the flag
			irq_pend_q <= irq_set | (irq_pend_q & ~irq_clr);
			vint_q <= (irq_set | (irq_pend_q & ~irq_clr)) & ~vre_q[`VTU_VRE_IRQ_DIS];
			ref_left_q <= line_en ? ref_load : ref_fire ? ref_left_q - 3'd1 : ref_left_q;
			refresh_req_q <= ref_fire;
			underline_q <= row_q == ul_q[4:0];
			cursor_addr_q <= cur_d;
			start_addr_q <= start_d;
		end
	end

	vtu_addr_gen #(
		.AW(AW)
	) u_addr (
		.clk(clk),
		.sys_rst(sys_rst),
		.char_en(char_en),
		.line_step(line_step),
		.row_adv(row_adv),
		.frame_start(frame_start),
		.disp_on(vdisp_q),
		.start_addr(start_d),
		.pitch(pitch_q),
		.dword_mode(ul_q[`VTU_UL_DWORD]),
		.byte_mode(mode_q[`VTU_MODE_BYTE]),
		.count4(ul_q[`VTU_UL_COUNT4]),
		.count2(mode_q[`VTU_MODE_COUNT2]),
		.wrap_sel(mode_q[`VTU_MODE_WRAP]),
		.mem_addr_q(mem_addr_q)
	);

	// checks
	logic [2:0] ref_seen_q;
	logic [2:0] ref_exp_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_seen_q <= 3'd0;
			ref_exp_q <= 3'd0;
		end else begin
			ref_seen_q <= line_en ? 3'd0 : ref_seen_q + {2'b00, refresh_req_q};
			if (line_en) ref_exp_q <= ref_load;
		end
	end

	sequence s_locked_vwrite;
		wr_data & vlock & (index_q == `VTU_IDX_VRS_LO || index_q == `VTU_IDX_VBE);
	endsequence
	sequence s_border_armed;
		border_evt & vre_q[`VTU_VRE_IRQ_CLR_N];
	endsequence

	a_vlock_hold: assert property (@(posedge clk) disable iff (sys_rst)
		s_locked_vwrite |=> $stable(vrs_lo_q) && $stable(vbe_q))
		else $error("vertical register changed under lock");
	a_mode_lock: assert property (@(posedge clk) disable iff (sys_rst)
		wr_data && mlock && index_q == `VTU_IDX_MODE |=> $stable(mode_q))
		else $error("mode register changed under lock");
	a_wprot_mask: assert property (@(posedge clk) disable iff (sys_rst)
		low_hit && wprot |=> (low_wr_q.strobe == (low_wr_q.index == 3'd7)) && (!low_wr_q.strobe || low_wr_q.mask == 8'h10))
		else $error("protected low write not masked");
	a_refresh_count: assert property (@(posedge clk) disable iff (sys_rst)
		line_en && ref_exp_q != 3'd0 && $past(ref_left_q) == 3'd0 && ref_left_q == 3'd0 |-> ref_seen_q == ref_exp_q)
		else $error("wrong refresh count for the line");
	a_irq_mask: assert property (@(posedge clk) disable iff (sys_rst)
		vre_q[`VTU_VRE_IRQ_DIS] [*2] |-> !vint_q)
		else $error("interrupt shown while disabled");
	a_irq_clear: assert property (@(posedge clk) disable iff (sys_rst)
		irq_clr && !irq_set |=> !irq_pend_q)
		else $error("pending interrupt not cleared");
	a_irq_raise: assert property (@(posedge clk) disable iff (sys_rst)
		s_border_armed ##0 !vre_q[`VTU_VRE_IRQ_DIS] |=> irq_pend_q && vint_q)
		else $error("interrupt not raised at bottom border");
	a_vsync_end: assert property (@(posedge clk) disable iff (sys_rst)
		vcnt_q[3:0] == vre_q[3:0] && vcnt_q != vrs |=> !vsync_q)
		else $error("sync not ended on match");
	a_vblank_end: assert property (@(posedge clk) disable iff (sys_rst)
		vcnt_q[7:0] == vbe_q && vcnt_q != vbs + 10'd1 |=> !vblank_q)
		else $error("blank not ended on match");
	a_vdisp_end: assert property (@(posedge clk) disable iff (sys_rst)
		vcnt_q == vde + 10'd1 && $stable(vde) |=> !vdisp_q)
		else $error("display not ended after last line");
	a_retrace_off: assert property (@(posedge clk) disable iff (sys_rst)
		!retrace_en [*2] |-> !vsync_q && !hsync_q)
		else $error("retrace output active while held off");
	a_index_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!wr_index |=> $stable(index_q))
		else $error("index changed without index write");
endmodule // vtu_vert_regs
`default_nettype wire

// >>> testbench/vtu_host_model.sv
// host processor model driving the index/data register port
`default_nettype none
module vtu_host_model
	import vtu_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output var vtu_pkg::vtu_host_req_s req,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// one index or data write, held until the taking edge
	task automatic put(input logic sel, input logic [7:0] d);
		#1 req = '{wr: 1'b1, rd: 1'b0, sel_data: sel, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask
	// one data read of the register that the index selects
	task automatic get(output logic [7:0] d);
		#1 req = '{wr: 1'b0, rd: 1'b1, sel_data: 1'b1, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
		@(posedge clk);
	endtask
endmodule // vtu_host_model
`default_nettype wire

// >>> testbench/vtu_vert_regs_tb.sv
// self-checking bench for the vertical timing register block
`default_nettype none
`include "vtu_cfg.svh"
module vtu_vert_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import vtu_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	vtu_host_req_s req;
	logic [7:0] rdata, idx;
	logic [7:0] lock = 8'h00;
	logic [9:0] vt = 10'h00f;
	vtu_mode_e cm = VTU_NATIVE;
	logic [15:0] pen = 16'ha5c3;
	logic le = 1'b0;
	logic ce = 1'b0;
	vtu_low_wr_s lw;
	logic vs_q, vb_q, vd_q, vi_q, rf;
	logic [17:0] cur, sa, ma;
	logic [7:0] ovf = 8'h00;
	logic [7:0] msl = 8'h00;
	logic hr = 1'b0;
	logic hs, ul;
	int mismatches = 0;
	int tests_run = 0;
	always #4 clk = ~clk;
	vtu_host_model host (.clk(clk), .req(req), .rdata(rdata));
	vtu_vert_regs uut (.clk(clk), .sys_rst(sys_rst), .host_req(req), .host_rdata_q(rdata), .index_q(idx),
		.ext_lock_reg(lock), .overflow_reg(ovf), .max_scan_reg(msl), .start_addr_high(8'h12),
		.vert_total(vt), .compat_mode(cm), .light_pen(pen), .low_wr_q(lw), .char_en(ce), .line_en(le),
		.hretrace_in(hr), .hsync_q(hs), .vsync_q(vs_q), .vblank_q(vb_q), .vdisp_q(vd_q), .vint_q(vi_q),
		.refresh_req_q(rf), .underline_q(ul), .cursor_addr_q(cur), .start_addr_q(sa), .mem_addr_q(ma));
	task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		host.put(1'b0, i);
		host.put(1'b1, d);
	endtask
	task automatic rreg(input logic [7:0] i, output logic [7:0] d);
		host.put(1'b0, i);
		host.get(d);
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic t_regs;
		logic [7:0] d;
		logic [7:0] ri [5] = '{8'h0d, 8'h0e, 8'h0f, 8'h12, 8'h13};
		logic [7:0] rv [5] = '{8'h5a, 8'hc3, 8'h7e, 8'h03, 8'h28};
		lock <= 8'h18;
		for (int i = 0; i < 5; i++) wreg(ri[i], rv[i]);
		for (int i = 0; i < 5; i++) begin
			rreg(ri[i], d);
			chk("readback", d, rv[i]);
		end
		chk("index", idx, 8'h13);
		rreg(8'h20, d);
		chk("unmapped", d, 8'h00);
		#1 chk("start", sa, 18'h3125a);
		chk("cursor", cur, 18'h3c37e);
		cm <= VTU_LEGACY_TEXT;
		rreg(`VTU_IDX_VRS_LO, d);
		chk("pen high", d, 8'h25);
		rreg(`VTU_IDX_VRE, d);
		chk("pen low", d, 8'hc3);
		chk("legacy cursor", cur, 18'h0037e);
		cm <= VTU_ENHANCED;
		rreg(`VTU_IDX_VRS_LO, d);
		chk("pen enhanced", d, 8'ha5);
		cm <= VTU_NATIVE;
		lock <= 8'h00;
	endtask
	task automatic t_lock;
		logic [7:0] d;
		wreg(`VTU_IDX_VRS_LO, 8'h05);
		lock <= 8'h01;
		wreg(`VTU_IDX_VRS_LO, 8'h22);
		rreg(`VTU_IDX_VRS_LO, d);
		chk("locked vrs", d, 8'h05);
		lock <= 8'h20;
		wreg(`VTU_IDX_MODE, 8'h40);
		rreg(`VTU_IDX_MODE, d);
		chk("locked mode", d, 8'h00);
		lock <= 8'h00;
		wreg(`VTU_IDX_MODE, 8'h40);
		rreg(`VTU_IDX_MODE, d);
		chk("mode", d, 8'h40);
	endtask
	task automatic t_protect;
		wreg(`VTU_IDX_VRE, 8'h80);
		wreg(8'h03, 8'hff);
		#1 chk("blocked strobe", lw.strobe, 1'b0);
		wreg(`VTU_IDX_OVERFLOW, 8'hff);
		#1 chk("compare strobe", {lw.strobe, lw.index, lw.mask}, {1'b1, 3'h7, 8'h10});
		wreg(`VTU_IDX_VRE, 8'h00);
		wreg(8'h03, 8'h55);
		#1 chk("low write", {lw.strobe, lw.index, lw.data}, {1'b1, 3'h3, 8'h55});
	endtask
	task automatic t_timing;
		int cnt;
		logic vs, vb, pend, dis, m;
		cnt = 0;
		vs = 1'b0;
		vb = 1'b0;
		pend = 1'b0;
		dis = 1'b0;
		m = 1'b0;
		wreg(`VTU_IDX_VRE, 8'h18);
		wreg(`VTU_IDX_VBS_LO, 8'h06);
		wreg(`VTU_IDX_VBE, 8'h0a);
		wreg(`VTU_IDX_MODE, 8'h00);
		for (int i = 0; i < 40; i++) begin
			if (i == 20) begin
				wreg(`VTU_IDX_MODE, 8'h80);
				m = 1'b1;
			end
			// clear and mask, then rearm masked, then unmask while pending
			if (i == 25) begin
				wreg(`VTU_IDX_VRE, 8'h28);
				pend = 1'b0;
				dis = 1'b1;
			end
			if (i == 26) wreg(`VTU_IDX_VRE, 8'h38);
			if (i == 37) begin
				wreg(`VTU_IDX_VRE, 8'h18);
				dis = 1'b0;
			end
			#1 le = 1'b1;
			@(posedge clk);
			le <= 1'b0;
			cnt = (cnt == 15) ? 0 : cnt + 1;
			if (cnt == 5) vs = 1'b1;
			else if (cnt == 8) vs = 1'b0;
			if (cnt == 7) vb = 1'b1;
			else if (cnt == 10) vb = 1'b0;
			if (cnt == 4) pend = 1'b1;
			repeat (4) @(posedge clk);
			#1 chk("vsync", vs_q, vs & m);
			chk("vblank", vb_q, vb);
			chk("vdisp", vd_q, cnt <= 3);
			chk("vint", vi_q, pend & ~dis);
			@(posedge clk);
		end
	endtask
	task automatic t_refresh(input logic [7:0] v, input int n);
		int k;
		k = 0;
		wreg(`VTU_IDX_VRE, v);
		#1 le = 1'b1;
		@(posedge clk);
		le <= 1'b0;
		repeat (8) begin
			#1 ce = 1'b1;
			@(posedge clk);
			ce <= 1'b0;
			#1 k += int'(rf);
			@(posedge clk);
		end
		chk("refresh count", 18'(k), 18'(n));
	endtask
	// two-line rows, retrace start moved above the frame, address reload and row step
	task automatic t_extra;
		wreg(`VTU_IDX_ULINE, 8'h01);
		ovf <= 8'h04;
		msl <= 8'h01;
		#1 hr = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("hsync", hs, 1'b1);
		@(posedge clk);
		hr <= 1'b0;
		for (int k = 1; k <= 8; k++) begin
			#1 le = 1'b1;
			@(posedge clk);
			le <= 1'b0;
			repeat (4) @(posedge clk);
			#1 chk("underline", ul, 18'(k % 2));
			chk("vsync high bits", vs_q, 1'b0);
			if (k == 6) chk("frame address", ma, 18'h024b4);
			if (k == 8) chk("row address", ma, 18'h025f4);
			@(posedge clk);
		end
		ovf <= 8'h00;
		msl <= 8'h00;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_lock();
		t_protect();
		t_timing();
		t_refresh(8'h18, 3);
		t_refresh(8'h58, 5);
		t_extra();
		give_verdict();
	end
endmodule // vtu_vert_regs_tb
`default_nettype wire
